// [vec_entry_pkg.sv]
// constants, types and helpers of the local vector entry and error status unit
// assumes one 40 MHz clock and a 4 KB register window addressed by byte offset
package vec_entry_pkg;
  localparam int          NUM_ENTRIES = 6;
  localparam int          IDX_W       = 3;
  localparam int          ADDR_W      = 12;
  localparam logic [2:0]  IDX_TIMER   = 3'h0;
  localparam logic [2:0]  IDX_THERMAL = 3'h1;
  localparam logic [2:0]  IDX_PERF    = 3'h2;
  localparam logic [2:0]  IDX_PIN0    = 3'h3;
  localparam logic [2:0]  IDX_PIN1    = 3'h4;
  localparam logic [2:0]  IDX_ERROR   = 3'h5;
  localparam logic [7:0]  REGION_TABLE = 8'h32;
  localparam logic [7:0]  REGION_LAST  = 8'h37;
  localparam logic [7:0]  REGION_ERRST = 8'h28;
  localparam int          VEC_LSB     = 0;
  localparam int          MODE_LSB    = 8;
  localparam int          STATUS_BIT  = 12;
  localparam int          POL_BIT     = 13;
  localparam int          REMOTE_BIT  = 14;
  localparam int          TRIG_BIT    = 15;
  localparam int          MASK_BIT    = 16;
  localparam int          TMODE_BIT   = 17;
  localparam logic [31:0] ENTRY_RESET = 32'h0001_0000;
  localparam logic [31:0] ENTRY_WMASK = 32'h0003_A7FF;
  localparam logic [2:0]  MODE_FIXED  = 3'h0;
  localparam logic [2:0]  MODE_SYSMGT = 3'h2;
  localparam logic [2:0]  MODE_NONMSK = 3'h4;
  localparam logic [2:0]  MODE_RESTRT = 3'h5;
  localparam logic [2:0]  MODE_EXTCTL = 3'h7;
  localparam logic [7:0]  VEC_MIN_LEGAL = 8'h10;
  localparam int          ERR_W          = 8;
  localparam int          ERR_SEND_CKSUM = 0;
  localparam int          ERR_RECV_CKSUM = 1;
  localparam int          ERR_SEND_ACC   = 2;
  localparam int          ERR_RECV_ACC   = 3;
  localparam int          ERR_SEND_ILL   = 5;
  localparam int          ERR_RECV_ILL   = 6;
  localparam int          ERR_ILL_REG    = 7;

  typedef struct packed {
    logic [7:0] vector;
    logic [2:0] mode;
    logic       level;
  } irq_t;

  typedef struct packed {
    logic send_cksum;
    logic recv_cksum;
    logic send_acc;
    logic recv_acc;
  } link_err_t;

  function automatic logic vec_legal(input logic [7:0] v);
    vec_legal = (v >= VEC_MIN_LEGAL);
  endfunction : vec_legal
endpackage : vec_entry_pkg

// [vec_entry_store.sv]
// configuration store of the six local vector entries
// masks each write to the writable fields with ENTRY_WMASK
`timescale 1ns/100ps
`default_nettype none
module vec_entry_store
  import vec_entry_pkg::*;
(
  input  wire logic                         mclk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         wr_en_in,
  input  wire logic [IDX_W-1:0]             wr_idx_in,
  input  wire logic [31:0]                  wr_data_in,
  input  wire logic [NUM_ENTRIES-1:0]       set_mask_in,
  input  wire logic [IDX_W-1:0]             rd_idx_in,
  output logic      [31:0]                  rd_data_out,
  output logic      [NUM_ENTRIES-1:0][31:0] cfg_out
);
  logic [NUM_ENTRIES-1:0][31:0] nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_out;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (wr_en_in && wr_idx_in == IDX_W'(i)) begin
        nxt_cfg[i] = wr_data_in & ENTRY_WMASK;
      end
      if (set_mask_in[i]) begin
        nxt_cfg[i][MASK_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_out     <= {NUM_ENTRIES{ENTRY_RESET}};
      rd_data_out <= 32'h0000_0000;
    end else begin
      cfg_out     <= nxt_cfg;
      rd_data_out <= (rd_idx_in < IDX_W'(NUM_ENTRIES)) ? cfg_out[rd_idx_in] : 32'h0000_0000;
    end
  end
endmodule : vec_entry_store
`default_nettype wire

// [local_vector_unit.sv]
// local vector entries, delivery to the core and error status register
// assumes core answers each delivery with one accept or retry pulse
`timescale 1ns/100ps
`default_nettype none
module local_vector_unit
  import vec_entry_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [31:0]       reg_wdata_in,
  output logic      [31:0]       reg_rdata_out,
  output logic                   reg_rvalid_out,
  input  wire logic              local_pin_input_zero_in,
  input  wire logic              local_pin_input_one_in,
  input  wire logic              timer_evt_in,
  input  wire logic              thermal_evt_in,
  input  wire logic              perf_evt_in,
  input  wire logic              io_unit_present_in,
  input  wire logic              send_vec_valid_in,
  input  wire logic [7:0]        send_vec_in,
  input  wire logic              recv_vec_valid_in,
  input  wire logic [7:0]        recv_vec_in,
  input  wire link_err_t         link_err_in,
  input  wire logic              core_accept_in,
  input  wire logic              core_retry_in,
  input  wire logic              end_of_service_command_in,
  input  wire logic [7:0]        end_of_service_vec_in,
  output logic                   irq_valid_out,
  output irq_t                   irq_out,
  output logic                   timer_periodic_out
);
  logic [NUM_ENTRIES-1:0][31:0] cfg;
  logic [31:0]                  store_rd;
  logic [NUM_ENTRIES-1:0]       prev_ff, pend_ff, sts_ff, remote_pending_ff;
  logic [NUM_ENTRIES-1:0]       nxt_pend, nxt_sts, nxt_remote;
  logic [NUM_ENTRIES-1:0]       act, rise, lvl, masked, bad, req, set_mask;
  logic                         busy_ff, timer_periodic_ff;
  logic [IDX_W-1:0]             cur_ff, pick;
  logic                         pick_ok;
  logic [ERR_W-1:0]             err_acc_ff, error_status_ff, new_err, err_rec;
  logic                         last_stat_wr_ff, rd1_ff, rd1_stat_ff;
  logic [IDX_W-1:0]             rd1_idx_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // register window decode
  wire logic [7:0]       region    = reg_addr_in[ADDR_W-1:4];
  wire logic             access    = reg_wr_in | reg_rd_in;
  wire logic             hit_table = (region >= REGION_TABLE) && (region <= REGION_LAST);
  wire logic             hit_stat  = (region == REGION_ERRST);
  wire logic [IDX_W-1:0] acc_idx   = IDX_W'(region - REGION_TABLE);
  wire logic             tbl_wr    = reg_wr_in & hit_table;
  wire logic             stat_wr   = reg_wr_in & hit_stat;
  wire logic             stat_clr  = stat_wr & last_stat_wr_ff;
  wire logic             err_masked = cfg[IDX_ERROR][MASK_BIT];
  wire logic             err_evt   = |(err_rec & ~err_acc_ff);
  wire logic [2:0]       wr_mode   = reg_wdata_in[MODE_LSB +: 3];
  wire logic             wr_bad    = tbl_wr && wr_mode == MODE_FIXED &&
                                     !vec_legal(reg_wdata_in[VEC_LSB +: 8]);
  wire logic             accepted  = busy_ff & core_accept_in;
  wire logic             returned  = busy_ff & core_retry_in;
  wire logic             launch    = !busy_ff && pick_ok && !bad[pick];
  wire logic             drop      = !busy_ff && pick_ok && bad[pick];

  vec_entry_store u_store (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (tbl_wr),
    .wr_idx_in   (acc_idx),
    .wr_data_in  (reg_wdata_in),
    .set_mask_in (set_mask),
    .rd_idx_in   (acc_idx),
    .rd_data_out (store_rd),
    .cfg_out     (cfg)
  );

  // source sensing per entry
  always_comb begin
    act            = {err_evt, local_pin_input_one_in, local_pin_input_zero_in,
                      perf_evt_in, thermal_evt_in, timer_evt_in};
    act[IDX_PIN0] = local_pin_input_zero_in ^ cfg[IDX_PIN0][POL_BIT];
    act[IDX_PIN1] = local_pin_input_one_in ^ cfg[IDX_PIN1][POL_BIT];
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      masked[i] = cfg[i][MASK_BIT];
      rise[i]   = act[i] & ~prev_ff[i];
      // pins only; timer and error stay edge
      lvl[i]    = (i == int'(IDX_PIN0) || i == int'(IDX_PIN1)) &&
                  (cfg[i][MODE_LSB +: 3] == MODE_EXTCTL ||
                   (cfg[i][MODE_LSB +: 3] == MODE_FIXED &&
                    (cfg[i][TRIG_BIT] || !io_unit_present_in)));
      bad[i]    = cfg[i][MODE_LSB +: 3] == MODE_FIXED && !vec_legal(cfg[i][VEC_LSB +: 8]);
      req[i]    = !masked[i] && !sts_ff[i] &&
                  (lvl[i] ? (act[i] & ~remote_pending_ff[i]) : pend_ff[i]);
    end
  end

  // lowest entry index wins
  always_comb begin
    pick    = '0;
    pick_ok = 1'b0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick    = IDX_W'(i);
        pick_ok = 1'b1;
      end
    end
  end

  // pending, status and remote flags
  always_comb begin
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      nxt_pend[i]   = pend_ff[i];
      nxt_sts[i]    = sts_ff[i];
      nxt_remote[i] = remote_pending_ff[i];
      set_mask[i]   = 1'b0;
      if ((launch || drop) && pick == IDX_W'(i)) begin
        nxt_pend[i] = 1'b0;
        nxt_sts[i]  = launch;
      end
      if ((accepted || returned) && cur_ff == IDX_W'(i)) begin
        nxt_sts[i] = 1'b0;
      end
      if (returned && cur_ff == IDX_W'(i) && !lvl[i]) begin
        nxt_pend[i] = 1'b1;
      end
      if (rise[i] && !masked[i] && !lvl[i]) begin
        nxt_pend[i] = 1'b1;
      end
      if (end_of_service_command_in && cfg[i][VEC_LSB +: 8] == end_of_service_vec_in) begin
        nxt_remote[i] = 1'b0;
      end
      if (accepted && cur_ff == IDX_W'(i) && irq_out.level && irq_out.mode == MODE_FIXED) begin
        nxt_remote[i] = 1'b1;
      end
      if (accepted && cur_ff == IDX_W'(i) && i == int'(IDX_PERF)) begin
        set_mask[i] = 1'b1;
      end
    end
  end

  // error collection
  always_comb begin
    new_err                 = '0;
    new_err[ERR_SEND_CKSUM] = link_err_in.send_cksum;
    new_err[ERR_RECV_CKSUM] = link_err_in.recv_cksum;
    new_err[ERR_SEND_ACC]   = link_err_in.send_acc;
    new_err[ERR_RECV_ACC]   = link_err_in.recv_acc;
    new_err[ERR_SEND_ILL]   = send_vec_valid_in && !vec_legal(send_vec_in);
    new_err[ERR_RECV_ILL]   = (recv_vec_valid_in && !vec_legal(recv_vec_in)) ||
                              drop || wr_bad;
    new_err[ERR_ILL_REG]    = access && !hit_table && !hit_stat;
    err_rec                 = err_masked ? '0 : new_err;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_ff           <= '0;
      pend_ff           <= '0;
      sts_ff            <= '0;
      remote_pending_ff <= '0;
    end else begin
      prev_ff           <= act;
      pend_ff           <= nxt_pend;
      sts_ff            <= nxt_sts;
      remote_pending_ff <= nxt_remote;
    end
  end

  // delivery to the core
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_ff       <= 1'b0;
      cur_ff        <= '0;
      irq_valid_out <= 1'b0;
      irq_out       <= '0;
    end else if (launch) begin
      busy_ff       <= 1'b1;
      cur_ff        <= pick;
      irq_valid_out <= 1'b1;
      irq_out       <= '{vector: cfg[pick][VEC_LSB +: 8],
                         mode: cfg[pick][MODE_LSB +: 3], level: lvl[pick]};
    end else if (accepted || returned) begin
      busy_ff       <= 1'b0;
      irq_valid_out <= 1'b0;
    end
  end

  // error status: sticky collector and software visible copy
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_acc_ff      <= '0;
      error_status_ff <= '0;
      last_stat_wr_ff <= 1'b0;
    end else begin
      if (stat_clr) begin
        err_acc_ff      <= err_rec;
        error_status_ff <= '0;
      end else begin
        err_acc_ff <= err_acc_ff | err_rec;
        if (stat_wr) begin
          error_status_ff <= err_acc_ff | err_rec;
        end
      end
      if (access) begin
        last_stat_wr_ff <= stat_wr & ~stat_clr;
      end
    end
  end

  // two stage read path and timer mode copy
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd1_ff             <= 1'b0;
      rd1_stat_ff        <= 1'b0;
      rd1_idx_ff         <= '0;
      reg_rvalid_out     <= 1'b0;
      reg_rdata_out      <= 32'h0000_0000;
      timer_periodic_ff  <= 1'b0;
      timer_periodic_out <= 1'b0;
    end else begin
      rd1_ff             <= reg_rd_in;
      rd1_stat_ff        <= hit_stat;
      rd1_idx_ff         <= acc_idx;
      reg_rvalid_out     <= rd1_ff;
      timer_periodic_ff  <= cfg[IDX_TIMER][TMODE_BIT];
      timer_periodic_out <= timer_periodic_ff;
      if (rd1_ff && rd1_stat_ff) begin
        reg_rdata_out <= {{(32 - ERR_W){1'b0}}, error_status_ff};
      end else if (rd1_ff) begin
        reg_rdata_out <= store_rd;
        reg_rdata_out[STATUS_BIT] <= sts_ff[rd1_idx_ff];
        reg_rdata_out[REMOTE_BIT] <= remote_pending_ff[rd1_idx_ff];
      end
    end
  end

  sequence s_first_write;
    stat_wr && !last_stat_wr_ff;
  endsequence

  sequence s_two_writes;
    s_first_write ##1 !access ##1 (reg_wr_in && hit_stat);
  endsequence

  a_status_on_launch:
    assert property (launch |=> irq_valid_out && sts_ff[cur_ff])
    else $error("delivery status not set on launch");
  a_status_clears:
    assert property ((accepted || returned) |=> !sts_ff[$past(cur_ff)] && !irq_valid_out)
    else $error("delivery status stuck after answer");
  a_remote_sets:
    assert property (accepted && irq_out.level && irq_out.mode == MODE_FIXED
                     && !end_of_service_command_in |=> remote_pending_ff[$past(cur_ff)])
    else $error("remote pending flag not set");
  a_perf_mask:
    assert property (accepted && cur_ff == IDX_PERF |=> cfg[IDX_PERF][MASK_BIT])
    else $error("performance entry not masked after handling");
  a_masked_no_launch:
    assert property (launch |-> !cfg[pick][MASK_BIT] && !bad[pick])
    else $error("masked or illegal entry launched");
  a_err_sticky:
    assert property (!stat_clr |=> (err_acc_ff & $past(err_acc_ff)) == $past(err_acc_ff))
    else $error("error bit lost without clear");
  a_mask_freezes:
    assert property (err_masked && !stat_clr |=> $stable(err_acc_ff))
    else $error("error recorded while error entry masked");
  a_low_vec_flag:
    assert property (recv_vec_valid_in && recv_vec_in < 8'h10 && !err_masked
                     |=> err_acc_ff[ERR_RECV_ILL])
    else $error("low vector not flagged");
  a_double_write:
    assert property (s_two_writes |=> error_status_ff == '0)
    else $error("second write did not clear status");
  a_err_raises:
    assert property (err_evt && !prev_ff[IDX_ERROR] && !bad[IDX_ERROR]
                     |=> pend_ff[IDX_ERROR] || sts_ff[IDX_ERROR])
    else $error("error interrupt not raised");
  a_drop_flagged:
    assert property (drop && !err_masked |=> err_acc_ff[ERR_RECV_ILL])
    else $error("dropped illegal vector not flagged");
  a_send_low_vec:
    assert property (send_vec_valid_in && !vec_legal(send_vec_in) && !err_masked
                     |=> err_acc_ff[ERR_SEND_ILL])
    else $error("illegal sent vector not flagged");
  a_bad_address:
    assert property (access && !hit_table && !hit_stat && !err_masked
                     |=> err_acc_ff[ERR_ILL_REG])
    else $error("illegal register address not flagged");
  a_fixed_vec_legal:
    assert property (launch && cfg[pick][MODE_LSB +: 3] == MODE_FIXED
                     |=> irq_out.vector >= VEC_MIN_LEGAL)
    else $error("fixed delivery with illegal vector");
  a_forced_edge:
    assert property (launch && cfg[pick][MODE_LSB +: 3] != MODE_FIXED
                     && cfg[pick][MODE_LSB +: 3] != MODE_EXTCTL |=> !irq_out.level)
    else $error("non fixed delivery not edge sensed");
  a_ext_level:
    assert property (launch && (pick == IDX_PIN0 || pick == IDX_PIN1)
                     && cfg[pick][MODE_LSB +: 3] == MODE_EXTCTL |=> irq_out.level)
    else $error("external controller delivery not level sensed");
  a_no_io_level:
    assert property (launch && (pick == IDX_PIN0 || pick == IDX_PIN1) && !io_unit_present_in
                     && cfg[pick][MODE_LSB +: 3] == MODE_FIXED |=> irq_out.level)
    else $error("fixed pin delivery not level sensed without io unit");
  a_timer_err_edge:
    assert property (launch && (pick == IDX_TIMER || pick == IDX_ERROR) |=> !irq_out.level)
    else $error("timer or error source not edge sensed");
endmodule : local_vector_unit
`default_nettype wire

// [core_model.sv]
// processor core model: answers each delivery with one accept or retry pulse
// assumes the unit holds irq valid until the answer is sampled; drives on falling edges
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       irq_valid_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       retry_req_in,
  output logic            accept_out,
  output logic            retry_out
);
  logic [3:0] wait_cnt_ff;
  // answer after delay_in cycles, pulse held for exactly one rising edge
  always @(negedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt_ff <= 4'h0;
      accept_out  <= 1'b0;
      retry_out   <= 1'b0;
    end else if (accept_out || retry_out || !irq_valid_in) begin
      accept_out  <= 1'b0;
      retry_out   <= 1'b0;
      wait_cnt_ff <= 4'h0;
    end else if (wait_cnt_ff == delay_in) begin
      accept_out  <= !retry_req_in;
      retry_out   <= retry_req_in;
    end else begin
      wait_cnt_ff <= wait_cnt_ff + 4'h1;
    end
  end
endmodule : core_model
`default_nettype wire

// [local_vector_unit_tb.sv]
// self-checking testbench of the local vector unit with a core model
// assumes one 40 MHz clock; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module local_vector_unit_tb;
  import vec_entry_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        rvalid;
  logic        pin0 = 1'b1;
  logic        pin1 = 1'b0;
  logic        tmr = 1'b0;
  logic        thm = 1'b0;
  logic        perf = 1'b0;
  logic        iop = 1'b1;
  logic        sv = 1'b0;
  logic [7:0]  svec = 8'h00;
  logic        rv = 1'b0;
  logic [7:0]  rvec = 8'h00;
  link_err_t   lerr = '0;
  logic        eos = 1'b0;
  logic [7:0]  eosvec = 8'h00;
  logic        irqv;
  irq_t        irq;
  logic        tper;
  logic        acc;
  logic        ret;
  logic [3:0]  dly = 4'h2;
  logic        rreq = 1'b0;
  int          n_fail = 0;
  int          n_compared = 0;
  logic [31:0] d;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  local_vector_unit u_local_vector_unit (.mclk_in(mclk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr_en), .reg_rd_in(rd_en), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .local_pin_input_zero_in(pin0),
    .local_pin_input_one_in(pin1), .timer_evt_in(tmr), .thermal_evt_in(thm),
    .perf_evt_in(perf), .io_unit_present_in(iop), .send_vec_valid_in(sv),
    .send_vec_in(svec), .recv_vec_valid_in(rv), .recv_vec_in(rvec), .link_err_in(lerr),
    .core_accept_in(acc), .core_retry_in(ret), .end_of_service_command_in(eos),
    .end_of_service_vec_in(eosvec), .irq_valid_out(irqv), .irq_out(irq),
    .timer_periodic_out(tper));

  core_model u_core_model (.mclk_in(mclk), .rst_n_in(rst_n), .irq_valid_in(irqv),
    .delay_in(dly), .retry_req_in(rreq), .accept_out(acc), .retry_out(ret));

  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    int i;
    addr = a;
    rd_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge mclk);
    if (rvalid !== 1'b1) begin
      n_fail++;
      final_report();
    end
    v = rdata;
  endtask : rd

  task automatic wait_lvl(input logic lvl);
    int i;
    for (i = 0; i < 40 && irqv !== lvl; i++) @(negedge mclk);
    if (irqv !== lvl) begin
      n_fail++;
      final_report();
    end
  endtask : wait_lvl

  task automatic serve(input logic [11:0] exp);
    wait_lvl(1'b1);
    check("irq", {20'h0, irq}, {20'h0, exp});
    wait_lvl(1'b0);
  endtask : serve

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(12'h320 + 12'(i * 16), d);
      check("entry reset", d, 32'h0001_0000);
    end
    rd(12'h280, d);
    check("errst reset", d, 32'h0000_0000);
  endtask : t_reset

  task automatic t_timer;
    wr(12'h320, 32'h0003_0000);
    repeat (4) @(negedge mclk);
    check("periodic", {31'h0, tper}, 32'h0000_0001);
    wr(12'h320, 32'h0001_0000);
    repeat (4) @(negedge mclk);
    check("one shot", {31'h0, tper}, 32'h0000_0000);
  endtask : t_timer

  task automatic t_perf;
    dly = 4'h8;
    wr(12'h340, 32'h0000_0040);
    perf = 1'b1;
    wait_lvl(1'b1);
    perf = 1'b0;
    check("perf irq", {20'h0, irq}, 32'h0000_0400);
    rd(12'h340, d);
    check("status busy", d, 32'h0000_1040);
    wait_lvl(1'b0);
    rd(12'h340, d);
    check("status idle", d, 32'h0001_0040);
    dly = 4'h2;
  endtask : t_perf

  task automatic t_pin;
    wr(12'h350, 32'h0000_A050);
    pin0 = 1'b0;
    serve(12'h501);
    pin0 = 1'b1;
    rd(12'h350, d);
    check("remote set", d, 32'h0000_E050);
    eosvec = 8'h50;
    eos = 1'b1;
    @(negedge mclk);
    eos = 1'b0;
    rd(12'h350, d);
    check("remote clr", d, 32'h0000_A050);
  endtask : t_pin

  task automatic t_modes;
    logic [31:0] ent [5] = '{32'h0000_8400, 32'h0000_8200, 32'h0000_8500,
                             32'h0000_0700, 32'h0000_0060};
    logic [3:0]  ml [5] = '{4'h8, 4'h4, 4'hA, 4'hF, 4'h1};
    dly = 4'h4;
    for (int i = 0; i < 5; i++) begin
      iop = (i != 4);
      wr(12'h360, ent[i]);
      pin1 = 1'b1;
      wait_lvl(1'b1);
      pin1 = 1'b0;
      check("mode level", {28'h0, irq[3:0]}, {28'h0, ml[i]});
      wait_lvl(1'b0);
      wr(12'h360, 32'h0001_0060);
    end
    eosvec = 8'h60;
    eos = 1'b1;
    @(negedge mclk);
    eos = 1'b0;
    iop = 1'b1;
    dly = 4'h2;
    rd(12'h360, d);
    check("remote clr pin1", d, 32'h0001_0060);
  endtask : t_modes

  task automatic t_retry;
    wr(12'h320, 32'h0000_0070);
    rreq = 1'b1;
    tmr = 1'b1;
    wait_lvl(1'b1);
    tmr = 1'b0;
    check("first try", {20'h0, irq}, 32'h0000_0700);
    wait_lvl(1'b0);
    rreq = 1'b0;
    serve(12'h700);
    wr(12'h320, 32'h0001_0000);
  endtask : t_retry

  task automatic t_errors;
    wr(12'h370, 32'h0000_0030);
    svec = 8'h05;
    rvec = 8'h10;
    sv = 1'b1;
    rv = 1'b1;
    @(negedge mclk);
    sv = 1'b0;
    rv = 1'b0;
    serve(12'h300);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("send ill", d, 32'h0000_0020);
    lerr = '1;
    @(negedge mclk);
    lerr = '0;
    serve(12'h300);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("link errs", d, 32'h0000_002F);
    wr(12'h280, 32'h0000_0000);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("cleared", d, 32'h0000_0000);
    rd(12'h100, d);
    serve(12'h300);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("ill addr", d, 32'h0000_0080);
    wr(12'h280, 32'h0000_0000);
    wr(12'h280, 32'h0000_0000);
  endtask : t_errors

  task automatic t_masked;
    wr(12'h370, 32'h0001_0030);
    svec = 8'h01;
    sv = 1'b1;
    @(negedge mclk);
    sv = 1'b0;
    repeat (6) @(negedge mclk);
    check("no err irq", {31'h0, irqv}, 32'h0000_0000);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("masked rec", d, 32'h0000_0000);
    wr(12'h370, 32'h0000_0030);
    wr(12'h330, 32'h0000_000A);
    serve(12'h300);
    thm = 1'b1;
    @(negedge mclk);
    thm = 1'b0;
    repeat (2) @(negedge mclk);
    check("dropped", {31'h0, irqv}, 32'h0000_0000);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("fixed low vec", d, 32'h0000_0040);
    wr(12'h280, 32'h0000_0000);
    wr(12'h280, 32'h0000_0000);
    rvec = 8'h0F;
    rv = 1'b1;
    @(negedge mclk);
    rv = 1'b0;
    serve(12'h300);
    wr(12'h280, 32'h0000_0000);
    rd(12'h280, d);
    check("recv low vec", d, 32'h0000_0040);
  endtask : t_masked

  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_timer();
    t_perf();
    t_pin();
    t_retry();
    t_modes();
    t_errors();
    t_masked();
    final_report();
  end
endmodule : local_vector_unit_tb
`default_nettype wire
